// file: design/dscg_regs.vh
// Register map, field positions and reset values of the clock gate bank
// Function
// RL1: Set gating bit clocks its unit
// RL2: Clear gating bit stops and disables unit
// RL3: Access to gated unit gets bus fault
// RL4: Gating bits reset to zero unless noted
// RL5: Software enables the units it needs
// RL6: Separate run, sleep and deep-sleep sets
// RL7: Sleep sets apply only with auto gating
// RL8: Deep-sleep register at 0x120, reset 0x40
// RL9: Bit 24 gates the CAN controller
// RL10: Bit 16 gates the analog sampler
// RL11: Bit 6 gates hibernation, resets one
// RL12: Bit 3 gates watchdog, resets zero
// RL13: Other bits read zero, writes ignored
// RL14: Deep-sleep set ignored outside deep-sleep
`ifndef DSCG_REGS_VH
`define DSCG_REGS_VH

// System control block base, for reference by the bus fabric
`define DSCG_SYSCTL_BASE 32'h400fe000

// Byte offsets within the system control block
`define DSCG_OFS_RUN_CFG 12'h060
`define DSCG_OFS_RUN_GATE 12'h100
`define DSCG_OFS_SLEEP_GATE 12'h110
`define DSCG_OFS_DEEP_GATE 12'h120
`define DSCG_OFS_IRQ_STAT 12'h180
`define DSCG_OFS_IRQ_MASK 12'h184
`define DSCG_OFS_GATE_STAT 12'h188

// Auto-gating select within the run clock configuration
`define DSCG_BIT_AUTO_GATE 27

// Unit enable positions in every gating register
`define DSCG_BIT_CAN 24
`define DSCG_BIT_ADC 16
`define DSCG_BIT_HIB 6
`define DSCG_BIT_WDT 3

// Full register reset values
`define DSCG_RST_GATE 32'h00000040
`define DSCG_RST_RUN_CFG 32'h00000000

// Gate status layout: effective enables low, mode above
`define DSCG_GSTAT_MODE_LSB 8

`endif

// file: design/dscg_clk_gate.v
// Glitch-free clock gate for one peripheral unit
`timescale 1ns/1ps
`default_nettype none
module dscg_clk_gate (
  input wire clk,
  input wire rstn,
  input wire enable,
  output wire gatedClk
);

  reg enLow_q;

  // Enable sampled on the falling edge of the clock so the gated pulse is never cut
  always @(negedge clk or negedge rstn) begin
    if (!rstn) begin
      enLow_q <= 1'b0;
    end else begin
      enLow_q <= enable;
    end
  end

  assign gatedClk = clk & enLow_q;

endmodule // dscg_clk_gate
`default_nettype wire

// file: design/dscg_event_irq.v
// Sticky event status with read-clear and masked interrupt
`timescale 1ns/1ps
`default_nettype none
module dscg_event_irq #(
  parameter N = 4
) (
  input wire mclk,
  input wire rstn,
  input wire [N-1:0] setEvent,
  input wire [N-1:0] clear,
  input wire [N-1:0] mask,
  output wire [N-1:0] status,
  output wire irq
);

  reg [N-1:0] status_q;
  wire [N-1:0] status_d;

  // A new event beats a clear in the same cycle
  assign status_d = (status_q & ~clear) | setEvent;

  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      status_q <= {N{1'b0}};
    end else begin
      status_q <= status_d;
    end
  end

  assign status = status_q;
  // Level output, high while any unmasked bit is set
  assign irq = |(status_q & mask);

endmodule // dscg_event_irq
`default_nettype wire

// file: design/dscg_bank0.v
// Clock gate bank 0: run, sleep and deep-sleep gating with APB access
//
// Decided for this implementation: the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "dscg_regs.vh"
module dscg_bank0 #(
  parameter UNITS = 4
) (
  input wire mclk,
  input wire rstn,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire pready,
  output wire pslverr,
  // Power mode from the power controller, same clock
  input wire sleepNow,
  input wire deepSleepNow,
  // Accesses aimed at each unit: 0 CAN, 1 ADC, 2 HIB, 3 WDT
  input wire [UNITS-1:0] unitSel,
  output wire [UNITS-1:0] unitFault,
  // Unit clocks and enables
  output wire [UNITS-1:0] unitClk,
  output wire [UNITS-1:0] unitEnable,
  output wire [1:0] powerMode,
  output wire irq
);

  // Power modes
  localparam MODE_RUN = 2'h0;
  localparam MODE_SLEEP = 2'h1;
  localparam MODE_DEEP = 2'h2;

  // Unit indexes inside the compact enable vectors
  localparam U_CAN = 0;
  localparam U_ADC = 1;
  localparam U_HIB = 2;
  localparam U_WDT = 3;

  // Configuration, mode and bus answer state
  reg autoGate_q;
  reg autoGate_d;
  reg [UNITS-1:0] runGate_q;
  reg [UNITS-1:0] runGate_d;
  reg [UNITS-1:0] sleepGate_q;
  reg [UNITS-1:0] sleepGate_d;
  reg [UNITS-1:0] deepGate_q;
  reg [UNITS-1:0] deepGate_d;
  reg [UNITS-1:0] irqMask_q;
  reg [UNITS-1:0] irqMask_d;
  reg [1:0] mode_q;
  reg [1:0] mode_d;
  reg [UNITS-1:0] unitEn_q;
  reg [UNITS-1:0] unitEn_d;
  reg [31:0] rdData_q;
  reg [31:0] rdData_d;
  reg rdErr_q;
  reg rdErr_d;
  reg rdStat_q;
  reg rdStat_d;

  // Bus decode and per-unit event nets
  wire setupPhase;
  wire accessPhase;
  wire wrAccess;
  wire rdAccess;
  wire [UNITS-1:0] faultEvent;
  wire [UNITS-1:0] statClear;
  wire [UNITS-1:0] irqStatus;

  // Spread the compact unit vector onto its register bit positions
  function [31:0] expandGate;
    input [3:0] v;
    begin
      expandGate = 32'h00000000;
      expandGate[`DSCG_BIT_CAN] = v[U_CAN]; // see RL9
      expandGate[`DSCG_BIT_ADC] = v[U_ADC]; // see RL10
      expandGate[`DSCG_BIT_HIB] = v[U_HIB]; // see RL11
      expandGate[`DSCG_BIT_WDT] = v[U_WDT]; // see RL12
    end
  endfunction

  // Gather the writable bits; all other bit positions are dropped
  function [3:0] packGate;
    input [31:0] w;
    begin
      packGate[U_CAN] = w[`DSCG_BIT_CAN];
      packGate[U_ADC] = w[`DSCG_BIT_ADC];
      packGate[U_HIB] = w[`DSCG_BIT_HIB];
      packGate[U_WDT] = w[`DSCG_BIT_WDT];
    end
  endfunction

  // Reset value in compact form, taken from the full register value
  localparam [31:0] RST_FULL = `DSCG_RST_GATE; // see RL8
  localparam [3:0] RST_UNITS = {
    RST_FULL[`DSCG_BIT_WDT],
    RST_FULL[`DSCG_BIT_HIB],
    RST_FULL[`DSCG_BIT_ADC],
    RST_FULL[`DSCG_BIT_CAN]
  };

  // APB phase decode; zero wait states, so every access ends in one cycle
  assign setupPhase = psel & ~penable;
  assign accessPhase = psel & penable;
  assign wrAccess = accessPhase & pwrite;
  assign rdAccess = accessPhase & ~pwrite;
  assign pready = 1'b1;

  // Register writes land only on the completing access cycle
  always @* begin
    autoGate_d = autoGate_q;
    runGate_d = runGate_q;
    sleepGate_d = sleepGate_q;
    deepGate_d = deepGate_q;
    irqMask_d = irqMask_q;
    if (wrAccess) begin
      case (paddr)
        `DSCG_OFS_RUN_CFG: begin
          autoGate_d = pwdata[`DSCG_BIT_AUTO_GATE];
        end
        `DSCG_OFS_RUN_GATE: begin
          runGate_d = packGate(pwdata); // see RL6
        end
        `DSCG_OFS_SLEEP_GATE: begin
          sleepGate_d = packGate(pwdata); // see RL6
        end
        `DSCG_OFS_DEEP_GATE: begin
          // Reserved positions are never stored, so they read zero
          deepGate_d = packGate(pwdata); // see RL8 see RL13
        end
        `DSCG_OFS_IRQ_MASK: begin
          irqMask_d = pwdata[UNITS-1:0];
        end
        default: begin
          autoGate_d = autoGate_q;
        end
      endcase
    end
  end

  // Configuration flops; hibernation stays clocked out of reset
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      autoGate_q <= 1'b0;
      runGate_q <= RST_UNITS; // see RL4 see RL11
      sleepGate_q <= RST_UNITS; // see RL4 see RL11
      deepGate_q <= RST_UNITS; // see RL4 see RL11 see RL12
      irqMask_q <= 4'h0;
    end else begin
      autoGate_q <= autoGate_d;
      runGate_q <= runGate_d;
      sleepGate_q <= sleepGate_d;
      deepGate_q <= deepGate_d;
      irqMask_q <= irqMask_d;
    end
  end

  // Read data captured in the setup cycle so prdata comes from a flop
  always @* begin
    rdData_d = 32'h00000000;
    rdErr_d = 1'b0;
    rdStat_d = 1'b0;
    if (setupPhase && !pwrite) begin
      case (paddr)
        `DSCG_OFS_RUN_CFG: begin
          rdData_d[`DSCG_BIT_AUTO_GATE] = autoGate_q;
        end
        `DSCG_OFS_RUN_GATE: begin
          rdData_d = expandGate(runGate_q);
        end
        `DSCG_OFS_SLEEP_GATE: begin
          rdData_d = expandGate(sleepGate_q);
        end
        `DSCG_OFS_DEEP_GATE: begin
          rdData_d = expandGate(deepGate_q); // see RL13
        end
        `DSCG_OFS_IRQ_STAT: begin
          rdData_d[UNITS-1:0] = irqStatus;
          rdStat_d = 1'b1;
        end
        `DSCG_OFS_IRQ_MASK: begin
          rdData_d[UNITS-1:0] = irqMask_q;
        end
        `DSCG_OFS_GATE_STAT: begin
          rdData_d[UNITS-1:0] = unitEn_q;
          rdData_d[`DSCG_GSTAT_MODE_LSB+1:`DSCG_GSTAT_MODE_LSB] = mode_q;
        end
        default: begin
          rdErr_d = 1'b1;
        end
      endcase
    end else if (setupPhase && pwrite) begin
      // Writes to read-only or unmapped words are refused
      case (paddr)
        `DSCG_OFS_RUN_CFG,
        `DSCG_OFS_RUN_GATE,
        `DSCG_OFS_SLEEP_GATE,
        `DSCG_OFS_DEEP_GATE,
        `DSCG_OFS_IRQ_MASK: begin
          rdErr_d = 1'b0;
        end
        default: begin
          rdErr_d = 1'b1;
        end
      endcase
    end
  end

  // Answer flops; held through the access cycle, zero otherwise
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rdData_q <= 32'h00000000;
      rdErr_q <= 1'b0;
      rdStat_q <= 1'b0;
    end else begin
      rdData_q <= rdData_d;
      rdErr_q <= rdErr_d;
      rdStat_q <= rdStat_d;
    end
  end

  // Error shows only in the access cycle; read data idles at zero
  assign prdata = rdData_q;
  assign pslverr = accessPhase & rdErr_q;

  // Clear only the bits software actually saw, so a late event survives
  assign statClear = (rdAccess && rdStat_q) ? rdData_q[UNITS-1:0] :
                     {UNITS{1'b0}};

  // Power mode tracker; deep-sleep takes priority over sleep
  always @* begin
    mode_d = mode_q;
    case (mode_q)
      MODE_RUN: begin
        if (deepSleepNow) begin
          mode_d = MODE_DEEP;
        end else if (sleepNow) begin
          mode_d = MODE_SLEEP;
        end
      end
      MODE_SLEEP: begin
        if (deepSleepNow) begin
          mode_d = MODE_DEEP;
        end else if (!sleepNow) begin
          mode_d = MODE_RUN;
        end
      end
      MODE_DEEP: begin
        // Leaving deep-sleep may drop straight into sleep
        if (!deepSleepNow) begin
          mode_d = sleepNow ? MODE_SLEEP : MODE_RUN;
        end
      end
      default: begin
        mode_d = MODE_RUN;
      end
    endcase
  end

  // Mode register; follows the mode pins one edge later
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      mode_q <= MODE_RUN;
    end else begin
      mode_q <= mode_d;
    end
  end

  // Mode is visible to the power controller and to software
  assign powerMode = mode_q;

  // Pick the gating set; without auto gating the run set always rules
  always @* begin
    unitEn_d = runGate_q;
    case (mode_q)
      MODE_RUN: begin
        // Deep-sleep set is stored but not applied here
        unitEn_d = runGate_q; // see RL14
      end
      MODE_SLEEP: begin
        // Auto gating off: sleep keeps the run set
        unitEn_d = autoGate_q ? sleepGate_q : runGate_q; // see RL7
      end
      MODE_DEEP: begin
        unitEn_d = autoGate_q ? deepGate_q : runGate_q; // see RL7
      end
      default: begin
        unitEn_d = runGate_q;
      end
    endcase
  end

  // Registered so each enable changes cleanly on one edge
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      // Run mode out of reset, so start from the run set's value
      unitEn_q <= RST_UNITS; // see RL4
    end else begin
      unitEn_q <= unitEn_d;
    end
  end

  // Units see only the registered enables
  assign unitEnable = unitEn_q; // see RL1 see RL2

  // One clock gate and one fault check per unit
  genvar i;
  generate
    for (i = 0; i < UNITS; i = i + 1) begin : gUnit
      // Falling-edge enable flop starts low, so no clock pulse escapes during reset
      dscg_clk_gate uGate (
        .clk(mclk),
        .rstn(rstn),
        .enable(unitEn_q[i]), // see RL1 see RL2
        .gatedClk(unitClk[i])
      );
      // Unclocked unit cannot answer, so the access faults instead
      assign faultEvent[i] = unitSel[i] & ~unitEn_q[i]; // see RL3
    end
  endgenerate

  // Fault answer is combinational, in the cycle of the access
  assign unitFault = faultEvent; // see RL3 see RL12

  // Each fault is also logged as a sticky interrupt event
  dscg_event_irq #(
    .N(UNITS)
  ) uIrq (
    .mclk(mclk),
    .rstn(rstn),
    .setEvent(faultEvent),
    .clear(statClear),
    .mask(irqMask_q),
    .status(irqStatus),
    .irq(irq)
  );

endmodule // dscg_bank0
`default_nettype wire

// file: test/dscg_bank0_assertions.sv
// Port checker for clock gate bank 0
`timescale 1ns/1ps
`default_nettype none
module dscg_bank0_checker #(
  parameter UNITS = 4
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic sleepNow,
  input wire logic deepSleepNow,
  input wire logic [UNITS-1:0] unitSel,
  input wire logic [UNITS-1:0] unitFault,
  input wire logic [UNITS-1:0] unitClk,
  input wire logic [UNITS-1:0] unitEnable,
  input wire logic [1:0] powerMode,
  input wire logic irq
);
  logic [3:0] runQ, sleepQ, deepQ, maskQ;
  logic autoQ;
  // Decode helpers; units packed as WDT, HIB, ADC, CAN
  wire logic wrAcc = psel && penable && pwrite;
  wire logic mapped = paddr inside {12'h060, 12'h100, 12'h110, 12'h120,
    12'h180, 12'h184, 12'h188};
  wire logic roWr = pwrite && (paddr == 12'h180 || paddr == 12'h188);
  wire logic [3:0] wdUnits = {pwdata[3], pwdata[6], pwdata[16], pwdata[24]};
  wire logic [3:0] expEn = (autoQ && powerMode == 2'd2) ? deepQ :
    (autoQ && powerMode == 2'd1) ? sleepQ : runQ;
  // Shadow of the writable state, only the bits that steer outputs
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      runQ <= 4'h4;
      sleepQ <= 4'h4;
      deepQ <= 4'h4;
      maskQ <= 4'h0;
      autoQ <= 1'b0;
    end else if (wrAcc) begin
      if (paddr == 12'h100) runQ <= wdUnits;
      if (paddr == 12'h110) sleepQ <= wdUnits;
      if (paddr == 12'h120) deepQ <= wdUnits;
      if (paddr == 12'h184) maskQ <= pwdata[3:0];
      if (paddr == 12'h060) autoQ <= pwdata[27];
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  a_fault_gated: assert property (
    unitFault == (unitSel & ~unitEnable)) else $error("fault mismatch");
  a_ready_high: assert property (
    pready) else $error("pready low");
  a_reserved_zero: assert property (
    (psel && penable && !pwrite && paddr == 12'h120) |->
    (prdata & 32'hfefeffb7) == 32'h00000000) else $error("reserved set");
  a_slverr_decode: assert property (
    (psel && penable) |-> pslverr == (!mapped || roWr))
    else $error("pslverr wrong");
  a_enable_select: assert property (
    1'b1 |=> unitEnable == $past(expEn)) else $error("enable set wrong");
  a_mode_follow: assert property (
    1'b1 |=> powerMode == $past(deepSleepNow ? 2'd2 : {1'b0, sleepNow}))
    else $error("mode wrong");
  a_irq_raise: assert property (
    |(unitFault & maskQ) |=> ##1 irq) else $error("irq missing");
  a_hib_reset: assert property (
    $rose(rstn) |-> unitEnable == 4'h4) else $error("reset enables wrong");
endmodule // dscg_bank0_checker
`default_nettype wire

// file: test/test_dscg_bank0.sv
// Self-checking bench for clock gate bank 0
`timescale 1ns/1ps
`default_nettype none
`include "dscg_regs.vh"
module test_dscg_bank0;
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic sleepNow = 1'b0;
  logic deepSleepNow = 1'b0;
  logic [3:0] unitSel = 4'h0;
  logic [31:0] prdata;
  logic pready, pslverr, irq;
  logic [3:0] unitFault, unitClk, unitEnable;
  logic [1:0] powerMode;
  int failures = 0;
  int samples_checked = 0;
  dscg_bank0 #(.UNITS(4)) i_dut (.mclk(mclk), .rstn(rstn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sleepNow(sleepNow), .deepSleepNow(deepSleepNow), .unitSel(unitSel),
    .unitFault(unitFault), .unitClk(unitClk), .unitEnable(unitEnable),
    .powerMode(powerMode), .irq(irq));
  // 25 MHz system clock
  always #20 mclk = ~mclk;
  task automatic end_of_test();
    $display("checked %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One APB transfer; request held until pready is seen high
  task automatic apbChk(input logic [11:0] a, input logic w,
    input logic [31:0] d, input logic [31:0] exp, input logic expErr);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1) @(posedge mclk);
    if (!w) chk(prdata, exp);
    chk(32'(pslverr), 32'(expErr));
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask
  // Mode then enable each take one cycle to follow; gated clocks are
  // looked at mid-high and mid-low, away from the edges that move them
  task automatic enChk(input logic [3:0] exp);
    repeat (3) @(posedge mclk);
    chk(32'(unitEnable), 32'(exp));
    #10 chk(32'(unitClk), 32'(exp));
    #20 chk(32'(unitClk), 32'h0);
    @(posedge mclk);
  endtask
  // Hang guard, far beyond the hundred or so cycles the run needs
  initial begin
    repeat (3000) @(posedge mclk);
    failures++;
    end_of_test();
  end
  // Main sequence
  initial begin
    repeat (4) @(posedge mclk);
    rstn <= 1'b1;
    @(posedge mclk);
    apbChk(`DSCG_OFS_DEEP_GATE, 1'b0, 0, 32'h00000040, 1'b0);
    enChk(4'h4);
    apbChk(`DSCG_OFS_DEEP_GATE, 1'b1, 32'hffffffff, 0, 1'b0);
    apbChk(`DSCG_OFS_DEEP_GATE, 1'b0, 0, 32'h01010048, 1'b0);
    apbChk(12'h124, 1'b0, 0, 32'h00000000, 1'b1);
    apbChk(`DSCG_OFS_GATE_STAT, 1'b1, 32'hf, 0, 1'b1);
    deepSleepNow <= 1'b1;
    enChk(4'h4);
    apbChk(`DSCG_OFS_RUN_CFG, 1'b1, 32'h08000000, 0, 1'b0);
    enChk(4'hf);
    apbChk(`DSCG_OFS_DEEP_GATE, 1'b1, 32'h00000008, 0, 1'b0);
    enChk(4'h8);
    chk(32'(powerMode), 32'h2);
    apbChk(`DSCG_OFS_GATE_STAT, 1'b0, 0, 32'h00000208, 1'b0);
    apbChk(`DSCG_OFS_RUN_CFG, 1'b0, 0, 32'h08000000, 1'b0);
    apbChk(`DSCG_OFS_SLEEP_GATE, 1'b0, 0, 32'h00000040, 1'b0);
    apbChk(`DSCG_OFS_RUN_GATE, 1'b0, 0, 32'h00000040, 1'b0);
    deepSleepNow <= 1'b0;
    sleepNow <= 1'b1;
    enChk(4'h4);
    chk(32'(powerMode), 32'h1);
    sleepNow <= 1'b0;
    enChk(4'h4);
    apbChk(`DSCG_OFS_IRQ_MASK, 1'b1, 32'hf, 0, 1'b0);
    apbChk(`DSCG_OFS_IRQ_MASK, 1'b0, 0, 32'h0000000f, 1'b0);
    apbChk(`DSCG_OFS_IRQ_STAT, 1'b1, 32'hf, 0, 1'b1);
    unitSel <= 4'hb;
    @(posedge mclk);
    chk(32'(unitFault), 32'hb);
    unitSel <= 4'h4;
    @(posedge mclk);
    chk(32'(unitFault), 32'h0);
    unitSel <= 4'h0;
    repeat (2) @(posedge mclk);
    chk(32'(irq), 32'h1);
    apbChk(`DSCG_OFS_IRQ_STAT, 1'b0, 0, 32'hb, 1'b0);
    @(posedge mclk);
    chk(32'(irq), 32'h0);
    apbChk(`DSCG_OFS_IRQ_STAT, 1'b0, 0, 32'h0, 1'b0);
    apbChk(`DSCG_OFS_IRQ_MASK, 1'b1, 32'h0, 0, 1'b0);
    unitSel <= 4'h8;
    @(posedge mclk);
    unitSel <= 4'h0;
    repeat (3) @(posedge mclk);
    chk(32'(irq), 32'h0);
    apbChk(`DSCG_OFS_IRQ_STAT, 1'b0, 0, 32'h8, 1'b0);
    // Mid-run reset, with a pending event, must restore the defaults
    unitSel <= 4'h1;
    @(posedge mclk);
    unitSel <= 4'h0;
    rstn <= 1'b0;
    repeat (4) @(posedge mclk);
    rstn <= 1'b1;
    @(posedge mclk);
    apbChk(`DSCG_OFS_IRQ_STAT, 1'b0, 0, 32'h0, 1'b0);
    apbChk(`DSCG_OFS_DEEP_GATE, 1'b0, 0, 32'h00000040, 1'b0);
    apbChk(`DSCG_OFS_RUN_CFG, 1'b0, 0, 32'h0, 1'b0);
    enChk(4'h4);
    end_of_test();
  end
endmodule // test_dscg_bank0
bind dscg_bank0 dscg_bank0_checker #(.UNITS(UNITS)) i_chk (.mclk(mclk),
  .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .sleepNow(sleepNow), .deepSleepNow(deepSleepNow),
  .unitSel(unitSel), .unitFault(unitFault), .unitClk(unitClk),
  .unitEnable(unitEnable), .powerMode(powerMode), .irq(irq));
`default_nettype wire
